// file: mxb_mem_model.sv
// External memory and peripheral model on the far side of the bus port
`timescale 1ns/1ps
module mxb_mem_model (
   input  wire logic       ale,
   input  wire logic       rd_n,
   input  wire logic       code_fetch_strobe_n,
   input  wire logic [7:0] bus_o,
   output logic      [7:0] bus_drv
);
   logic [7:0] addr_q = 8'h00;
   always @(negedge ale) addr_q = bus_o;
   // data only while a strobe is low
   // With both strobes high the bus shows the latched address itself, not its inverse
   assign bus_drv = (!rd_n || !code_fetch_strobe_n) ? ~addr_q : addr_q;
endmodule

// file: mxb_pin_ctrl.sv
// External bus, port and low-power pin control of the 8-bit microcomputer
`timescale 1ns/1ps

// Contract
// - Reset pin initialises core, releases halt/stop
// - Single-step holds fetch with address strobe; only external fetches are held
// - Interrupt low acts only after enable
// - Reset disables external interrupt
// - External select forces external program fetches
// - Read strobe pulses on reads; bus floats
// - Write strobe pulses on bus/data writes
// - Code-fetch strobe only on external fetches
// - Address strobe pulses every machine cycle
// - Bidirectional bus, strobed or statically latched
// - Bus carries low address, then data
// - Port 2 low nibble holds high PC
// - Port 2 nibble expander bus, strobe qualifies
// - Standby low during reset enters stop
// - Halt op freezes; interrupt or reset wakes
// - Test input 1 testable, event count source
// - Test input 0 testable, state clock out
// - Two 8-bit quasi-bidirectional ports
// - 12-bit PC, 1K ROM, 64-byte RAM
// - Instructions take one or two cycles
// - External and timer interrupt sources
// - Opcode 01H is the halt instruction
// - Wake with enable runs next op first
module mxb_pin_ctrl
   import mxb_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                reset_pin_n,
   input  wire logic                standby_n,
   input  wire logic                single_step_n,
   input  wire logic                int_n,
   input  wire logic                external_code_select,
   input  wire logic                test_in_zero_i,
   output logic                     test_in_zero_o,
   output logic                     test_in_zero_oe,
   input  wire logic                count_test_in,
   output logic                     ale,
   output logic                     rd_n,
   output logic                     wr_n,
   output logic                     code_fetch_strobe_n,
   output logic                     expander_strobe,
   input  wire logic [7:0]          bus_i,
   output logic      [7:0]          bus_o,
   output logic                     bus_oe,
   input  wire logic [7:0]          p1_i,
   output logic      [7:0]          p1_o,
   output logic      [7:0]          p1_oe,
   input  wire logic [7:0]          p2_i,
   output logic      [7:0]          p2_o,
   output logic      [7:0]          p2_oe,
   output logic                     core_reset,
   output logic                     core_run,
   input  wire mxb_kind_type        req_kind,
   input  wire logic [PC_W-1:0]     req_addr,
   input  wire logic [7:0]          req_wdata,
   output logic                     cyc_start,
   output logic                     cyc_done,
   output logic      [7:0]          cyc_rdata,
   input  wire logic                op_valid,
   input  wire logic [7:0]          op_code,
   input  wire logic                ei_op,
   input  wire logic                di_op,
   input  wire logic                start_event_count_op,
   input  wire logic                stop_count_op,
   input  wire logic                clock_to_test_pin_op,
   input  wire logic                timer_ovf,
   input  wire logic                irq_ack,
   output logic                     ext_irq,
   output logic                     timer_irq,
   output logic                     int_level,
   output logic                     t0_level,
   output logic                     t1_level,
   output logic                     count_pulse,
   input  wire logic                p1_wr,
   input  wire logic                p2_wr,
   input  wire logic [7:0]          port_wdata,
   output logic      [7:0]          p1_level,
   output logic      [7:0]          p2_level,
   input  wire logic                rom_wr,
   input  wire logic [ROM_AW-1:0]   rom_waddr,
   input  wire logic [7:0]          rom_wdata,
   output logic                     halt_mode,
   output logic                     stop_mode
);

   logic [30:0]            sync1_q;
   logic [30:0]            sync2_q;
   logic                   t1_prev_q;
   logic [SLOT_CNT_W-1:0]  slot_cnt_q;
   logic                   slot_en_q;
   logic                   state_clk_q;
   mxb_slot_type           slot_q;
   mxb_kind_type           kind_q;
   logic [PC_W-1:0]        addr_q;
   logic [7:0]             wdata_q;
   logic                   ext_q;
   logic [7:0]             bus_latch_q;
   logic                   bus_static_q;
   logic                   p2_ovr_q;
   logic [3:0]             p2_nib_q;
   logic                   p2_nib_oe_q;
   logic [7:0]             p1_latch_q;
   logic [7:0]             p2_latch_q;
   logic                   int_en_q;
   logic                   wake_hold_q;
   logic                   t0_clk_q;
   logic                   count_mode_q;
   logic [7:0]             rom_mem [0:ROM_BYTES-1];
   logic [7:0]             ram_mem [0:RAM_BYTES-1];
   logic                   run;
   logic                   ram_we;

   // Two-flop synchroniser for every pin input; only stage two is read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
      end else begin
         sync1_q <= {reset_pin_n, standby_n, single_step_n, int_n, external_code_select,
                     test_in_zero_i, count_test_in, bus_i, p1_i, p2_i};
         sync2_q <= sync1_q;
      end
   end

   // Core held while reset pin low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_reset <= 1'b1;
      end else begin
         core_reset <= ~sync2_q[SY_RESET];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stop_mode <= 1'b0;
      end else if (!sync2_q[SY_RESET]) begin
         stop_mode <= ~sync2_q[SY_STBY];
      end
   end

   // Halt entry on opcode, wake on interrupt or reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         halt_mode   <= 1'b0;
         wake_hold_q <= 1'b0;
      end else if (core_reset) begin
         halt_mode   <= 1'b0;
         wake_hold_q <= 1'b0;
      end else if (op_valid && op_code == HALT_OPCODE && !halt_mode) begin
         halt_mode <= 1'b1;
      end else if (halt_mode && !sync2_q[SY_INT]) begin
         halt_mode   <= 1'b0;
         wake_hold_q <= int_en_q;
      end else if (op_valid) begin
         wake_hold_q <= 1'b0;
      end
   end

   assign run = ~halt_mode & ~stop_mode & ~core_reset;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_run <= 1'b0;
      end else begin
         core_run <= run;
      end
   end

   // Slot divider; it stops in stop mode since clock generation is off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_cnt_q  <= '0;
         slot_en_q   <= 1'b0;
         state_clk_q <= 1'b0;
      end else if (stop_mode) begin
         slot_en_q <= 1'b0;
      end else if (slot_cnt_q == SLOT_CNT_W'(SLOT_CYC - 1)) begin
         slot_cnt_q  <= '0;
         slot_en_q   <= 1'b1;
         state_clk_q <= ~state_clk_q;
      end else begin
         slot_cnt_q <= slot_cnt_q + 1'b1;
         slot_en_q  <= 1'b0;
      end
   end

   // Interrupt enable flag; cleared by reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_en_q <= 1'b0;
      end else if (core_reset || di_op) begin
         int_en_q <= 1'b0;
      end else if (ei_op) begin
         int_en_q <= 1'b1;
      end
   end

   // Both interrupt sources; timer event wins over acknowledge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_irq   <= 1'b0;
         timer_irq <= 1'b0;
         int_level <= 1'b0;
      end else begin
         ext_irq   <= int_en_q & ~sync2_q[SY_INT] & ~wake_hold_q & run;
         int_level <= ~sync2_q[SY_INT];
         if (core_reset) begin
            timer_irq <= 1'b0;
         end else if (timer_ovf) begin
            timer_irq <= 1'b1;
         end else if (irq_ack) begin
            timer_irq <= 1'b0;
         end
      end
   end

   // Test input 1 level and event-count edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_mode_q <= 1'b0;
         t1_prev_q    <= 1'b0;
         t1_level     <= 1'b0;
         count_pulse  <= 1'b0;
      end else begin
         t1_prev_q <= sync2_q[SY_T1];
         t1_level  <= sync2_q[SY_T1];
         if (core_reset || stop_count_op) begin
            count_mode_q <= 1'b0;
         end else if (start_event_count_op) begin
            count_mode_q <= 1'b1;
         end
         count_pulse <= count_mode_q & t1_prev_q & ~sync2_q[SY_T1];  // Falling edge counts
      end
   end

   // Test input 0 level and state clock out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         t0_clk_q        <= 1'b0;
         t0_level        <= 1'b0;
         test_in_zero_o  <= 1'b0;
         test_in_zero_oe <= 1'b0;
      end else begin
         if (core_reset) begin
            t0_clk_q <= 1'b0;
         end else if (clock_to_test_pin_op) begin
            t0_clk_q <= 1'b1;
         end
         t0_level        <= sync2_q[SY_T0];
         test_in_zero_o  <= state_clk_q;
         test_in_zero_oe <= t0_clk_q;
      end
   end

   // Quasi-bidirectional ports drive low only where latched zero, except the port 2 nibble under override
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         p1_latch_q <= PORT_RST;
         p2_latch_q <= PORT_RST;
         p1_o       <= PORT_RST;
         p1_oe      <= 8'h00;
         p2_o       <= PORT_RST;
         p2_oe      <= 8'h00;
         p1_level   <= 8'h00;
         p2_level   <= 8'h00;
      end else begin
         if (p1_wr) begin
            p1_latch_q <= port_wdata;
         end
         if (p2_wr) begin
            p2_latch_q <= port_wdata;
         end
         p1_o     <= p1_latch_q;
         p1_oe    <= ~p1_latch_q;
         p1_level <= sync2_q[SY_P1 +: 8];
         p2_level <= sync2_q[SY_P2 +: 8];
         // High PC nibble or expander nibble overrides
         p2_o     <= p2_ovr_q ? {p2_latch_q[7:4], p2_nib_q} : p2_latch_q;
         p2_oe    <= p2_ovr_q ? {~p2_latch_q[7:4], {4{p2_nib_oe_q}}} : ~p2_latch_q;
      end
   end

   // Internal program ROM, loaded through its own write port
   always_ff @(posedge clk) begin
      if (rom_wr) begin
         rom_mem[rom_waddr] <= rom_wdata;
      end
   end

   // Internal data RAM written at the end of the latch slot
   assign ram_we = run && slot_en_q && slot_q == SL_LATCH && kind_q == K_RAM_WR;

   always_ff @(posedge clk) begin
      if (ram_we) begin
         ram_mem[addr_q[RAM_AW-1:0]] <= wdata_q;
      end
   end

   // Machine-cycle sequencer driving the bus, strobes and port 2 nibble
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_q              <= SL_END;
         kind_q              <= K_IDLE;
         addr_q              <= '0;
         wdata_q             <= 8'h00;
         ext_q               <= 1'b0;
         ale                 <= 1'b0;
         rd_n                <= 1'b1;
         wr_n                <= 1'b1;
         code_fetch_strobe_n <= 1'b1;
         expander_strobe     <= 1'b1;             // Idles high; only its fall qualifies
         bus_o               <= BUS_LATCH_RST;
         bus_oe              <= 1'b0;
         bus_latch_q         <= BUS_LATCH_RST;
         bus_static_q        <= 1'b0;
         p2_ovr_q            <= 1'b0;
         p2_nib_q            <= 4'h0;
         p2_nib_oe_q         <= 1'b0;
         cyc_start           <= 1'b0;
         cyc_done            <= 1'b0;
         cyc_rdata           <= 8'h00;
      end else if (!run) begin
         // Frozen between cycles; static latch stays on the bus
         slot_q              <= SL_END;
         kind_q              <= K_IDLE;
         ale                 <= 1'b0;
         rd_n                <= 1'b1;
         wr_n                <= 1'b1;
         code_fetch_strobe_n <= 1'b1;
         expander_strobe     <= 1'b1;
         p2_ovr_q            <= 1'b0;
         bus_o               <= bus_latch_q;
         bus_oe              <= bus_static_q;
         cyc_start           <= 1'b0;
         cyc_done            <= 1'b0;
      end else begin
         cyc_start <= 1'b0;
         cyc_done  <= 1'b0;
         if (slot_en_q) begin
            unique case (slot_q)
               SL_END: begin
                  // One request per machine cycle; core chains two for long ops
                  slot_q    <= SL_ADDR;
                  kind_q    <= req_kind;
                  addr_q    <= req_addr;
                  wdata_q   <= req_wdata;
                  cyc_start <= 1'b1;
                  ale       <= 1'b1;
                  // External select or high address goes off-chip
                  ext_q     <= sync2_q[SY_EXT] | (|req_addr[PC_W-1:ROM_AW]);
                  if ((req_kind == K_FETCH && (sync2_q[SY_EXT] | (|req_addr[PC_W-1:ROM_AW])))
                      || req_kind == K_XRD || req_kind == K_XWR) begin
                     bus_o  <= req_addr[7:0];
                     bus_oe <= 1'b1;
                  end
                  if (req_kind == K_FETCH && (sync2_q[SY_EXT] | (|req_addr[PC_W-1:ROM_AW]))) begin
                     // High PC bits on port 2
                     p2_ovr_q    <= 1'b1;
                     p2_nib_q    <= req_addr[PC_W-1:8];
                     p2_nib_oe_q <= 1'b1;
                  end
                  if (req_kind == K_EXP_RD || req_kind == K_EXP_WR) begin
                     // Command nibble set up before the strobe falls
                     expander_strobe <= 1'b1;
                     p2_ovr_q        <= 1'b1;
                     p2_nib_q        <= req_addr[3:0];
                     p2_nib_oe_q     <= 1'b1;
                  end
               end
               SL_ADDR: begin
                  // Step mode parks an external fetch with the strobe high
                  if (!(kind_q == K_FETCH && ext_q && !sync2_q[SY_STEP])) begin
                     slot_q <= SL_LATCH;
                     ale    <= 1'b0;
                     if (kind_q == K_EXP_RD || kind_q == K_EXP_WR) begin
                        expander_strobe <= 1'b0;
                        p2_nib_q        <= wdata_q[3:0];
                        p2_nib_oe_q     <= (kind_q == K_EXP_WR);
                     end
                  end
               end
               SL_LATCH: begin
                  slot_q <= SL_STRB1;
                  unique case (kind_q)
                     K_FETCH: begin
                        code_fetch_strobe_n <= ~ext_q;
                        if (ext_q) begin
                           bus_oe <= 1'b0;
                        end
                     end
                     // Read strobe, bus released to peripheral
                     K_XRD, K_BUS_IN: begin
                        rd_n   <= 1'b0;
                        bus_oe <= 1'b0;
                     end
                     // Write strobe with data on the bus
                     K_XWR: begin
                        wr_n   <= 1'b0;
                        bus_o  <= wdata_q;
                        bus_oe <= 1'b1;
                     end
                     K_BUS_OUT: begin
                        wr_n         <= 1'b0;
                        bus_o        <= wdata_q;
                        bus_oe       <= 1'b1;
                        bus_latch_q  <= wdata_q;
                        bus_static_q <= 1'b1;
                     end
                     default: begin
                     end
                  endcase
               end
               SL_STRB1: begin
                  slot_q <= SL_STRB2;
               end
               SL_STRB2: begin
                  slot_q              <= SL_END;
                  cyc_done            <= 1'b1;
                  rd_n                <= 1'b1;
                  wr_n                <= 1'b1;
                  code_fetch_strobe_n <= 1'b1;
                  p2_ovr_q            <= 1'b0;
                  if (kind_q == K_EXP_RD || kind_q == K_EXP_WR) begin
                     expander_strobe <= 1'b1;
                  end
                  unique case (kind_q)
                     K_FETCH:  cyc_rdata <= ext_q ? sync2_q[SY_BUS +: 8]
                                                  : rom_mem[addr_q[ROM_AW-1:0]];
                     K_XRD:    cyc_rdata <= sync2_q[SY_BUS +: 8];
                     K_BUS_IN: cyc_rdata <= sync2_q[SY_BUS +: 8];
                     K_EXP_RD: cyc_rdata <= {4'h0, sync2_q[SY_P2 +: 4]};
                     K_RAM_RD: cyc_rdata <= ram_mem[addr_q[RAM_AW-1:0]];
                     default:  cyc_rdata <= cyc_rdata;
                  endcase
                  // Back to static latch or float; a bus input (K_BUS_IN) read drops it
                  if (kind_q == K_BUS_IN) begin
                     bus_static_q <= 1'b0;
                     bus_oe       <= 1'b0;
                  end else begin
                     bus_o  <= bus_latch_q;
                     bus_oe <= bus_static_q;
                  end
               end
            endcase
         end
      end
   end

   // Checks on the pin behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_ale_period: assert property ($fell(ale) && run |-> ##[99:101] (ale || !run))
      else $error("address strobe missed a machine cycle");
   a_code_fetch_strobe_n_offchip: assert property (!code_fetch_strobe_n |-> kind_q == K_FETCH && ext_q)
      else $error("code-fetch strobe on an internal cycle");
   a_strobe_excl: assert property ($onehot0({~rd_n, ~wr_n, ~code_fetch_strobe_n}))
      else $error("two bus strobes active together");
   a_read_float: assert property (!rd_n |-> !bus_oe)
      else $error("bus driven during read strobe");
   a_write_data: assert property ($fell(wr_n) |-> bus_oe && bus_o == wdata_q)
      else $error("write strobe without write data");
   a_irq_gated: assert property (ext_irq |-> $past(int_en_q) && !$past(sync2_q[SY_INT]))
      else $error("interrupt raised while disabled");
   a_halt_freeze: assert property (halt_mode && $past(halt_mode) |-> !cyc_start)
      else $error("cycle started in halt");
   a_stop_quiet: assert property (stop_mode && $past(stop_mode) |-> !ale && !slot_en_q)
      else $error("activity in stop mode");
   a_reset_irq: assert property (core_reset |=> !int_en_q)
      else $error("interrupt left enabled by reset");

   c_ext_fetch: cover property ($fell(code_fetch_strobe_n));
   c_bus_write: cover property ($fell(wr_n) && kind_q == K_BUS_OUT);
   c_halt_wake: cover property ($fell(halt_mode) && !core_reset);
   c_exp_cycle: cover property ($rose(expander_strobe) && kind_q == K_EXP_WR);

endmodule

// file: mxb_pin_ctrl_test.sv
// Self-checking bench for the external bus and pin control block
`timescale 1ns/1ps
module mxb_pin_ctrl_test
   import mxb_pkg::*;
;
   logic clk, rst, reset_pin_n, standby_n, single_step_n, int_n, external_code_select;
   logic test_in_zero_i, test_in_zero_o, test_in_zero_oe, count_test_in, ale, rd_n, wr_n;
   logic code_fetch_strobe_n, expander_strobe, bus_oe, core_reset, core_run, cyc_start;
   logic cyc_done, op_valid, ei_op, di_op, start_event_count_op, stop_count_op, halt_mode;
   logic clock_to_test_pin_op, timer_ovf, irq_ack, ext_irq, timer_irq, int_level, t0_level;
   logic t1_level, count_pulse, p1_wr, p2_wr, rom_wr, stop_mode;
   logic [7:0] bus_i, bus_o, p1_i, p1_o, p1_oe, p2_i, p2_o, p2_oe, req_wdata, cyc_rdata;
   logic [7:0] op_code, port_wdata, p1_level, p2_level, rom_wdata, drv;
   logic [PC_W-1:0] req_addr;
   logic [ROM_AW-1:0] rom_waddr;
   mxb_kind_type req_kind;
   int err_count, checks_done, cyc_q;

   mxb_pin_ctrl mxb_pin_ctrl_inst (.*);
   mxb_mem_model mxb_mem_model_inst (.ale, .rd_n, .code_fetch_strobe_n, .bus_o, .bus_drv(drv));

   // Wire levels: pull-ups on quasi ports, model on a released bus
   assign bus_i = bus_oe ? bus_o : drv;
   assign p1_i = ~p1_oe;
   assign p2_i = ~p2_oe;
   assign test_in_zero_i = test_in_zero_oe & test_in_zero_o;

   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic tk(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One machine cycle: strobes mid-cycle, read data at its end
   task automatic cyc(mxb_kind_type k, logic [11:0] a, logic [7:0] w, logic [2:0] s,
                      logic oe, logic [7:0] e);
      int n;
      logic x;
      x = (k == K_FETCH) && !s[2];
      req_kind = k;
      req_addr = a;
      req_wdata = w;
      for (n = 0; n < 200 && cyc_start !== 1'b1; n++) tk(1);
      req_kind = K_IDLE;
      chk("ale", 12'h001, ale);
      if (x || k inside {K_XRD, K_XWR}) chk("adr", {4'h1, a[7:0]}, {bus_oe, bus_o});
      tk(60);
      chk("exs", !(k inside {K_EXP_RD, K_EXP_WR}), expander_strobe);
      chk("stb", s, {code_fetch_strobe_n, rd_n, wr_n});
      chk("boe", oe, bus_oe);
      if (oe) chk("wd", w, bus_o);
      if (x) chk("p2a", a[11:8], p2_o[3:0]);
      if (k == K_EXP_WR) chk("p2d", w[3:0], p2_o[3:0]);
      for (n = 0; n < 100 && cyc_done !== 1'b1; n++) tk(1);
      if (k inside {K_FETCH, K_XRD, K_BUS_IN, K_RAM_RD}) chk("rdd", e, cyc_rdata);
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cyc_q++;
      if (cyc_q == 20000) begin
         err_count++;
         end_sim();
      end
   end

   initial begin
      {rst, reset_pin_n, standby_n, single_step_n, int_n, external_code_select} = 6'h3F;
      {count_test_in, op_valid, ei_op, di_op, start_event_count_op, stop_count_op} = 6'h00;
      {clock_to_test_pin_op, timer_ovf, irq_ack, p1_wr, p2_wr, rom_wr} = 6'h01;
      {op_code, port_wdata, rom_wdata, req_wdata} = 32'h0000_6900;
      // One ROM byte loaded while reset holds the core
      {rom_waddr, req_addr} = {10'h035, 12'h000};
      req_kind = K_IDLE;
      tk(2);
      rst = 1'b0;
      rom_wr = 1'b0;
      repeat (100) if (core_run !== 1'b1) tk(1);
      chk("run", 12'h001, core_run);
      cyc(K_FETCH, 12'h335, 8'h00, 3'h3, 1'b0, 8'hCA);
      external_code_select = 1'b0;
      cyc(K_FETCH, 12'h035, 8'h00, 3'h7, 1'b0, 8'h69);
      // Single step parks a high-address fetch with the strobe up
      single_step_n = 1'b0;
      req_kind = K_FETCH;
      req_addr = 12'hC23;
      while (cyc_start !== 1'b1) tk(1);
      req_kind = K_IDLE;
      tk(60);
      chk("ss", 12'h003, {ale, code_fetch_strobe_n});
      single_step_n = 1'b1;
      while (cyc_done !== 1'b1) tk(1);
      chk("ssd", 12'h0DC, cyc_rdata);
      cyc(K_XRD, 12'h05C, 8'h00, 3'h5, 1'b0, 8'hA3);
      cyc(K_XWR, 12'h011, 8'h96, 3'h6, 1'b1, 8'h00);
      cyc(K_RAM_WR, 12'h020, 8'h5A, 3'h7, 1'b0, 8'h00);
      cyc(K_RAM_RD, 12'h020, 8'h00, 3'h7, 1'b0, 8'h5A);
      cyc(K_EXP_WR, 12'h004, 8'h09, 3'h7, 1'b0, 8'h00);
      cyc(K_BUS_OUT, 12'h000, 8'h3C, 3'h6, 1'b1, 8'h00);
      tk(30);
      chk("lat", 12'h13C, {bus_oe, bus_o});
      cyc(K_BUS_IN, 12'h000, 8'h00, 3'h5, 1'b0, 8'hC3);
      tk(30);
      chk("flt", 12'h000, bus_oe);
      // Timer flag, test pins and port 1 in one pass
      {start_event_count_op, clock_to_test_pin_op, count_test_in, timer_ovf, p1_wr} = 5'h1F;
      port_wdata = 8'hA5;
      tk(1);
      {start_event_count_op, clock_to_test_pin_op, timer_ovf, p1_wr} = 4'h0;
      chk("tmr", 12'h001, timer_irq);
      {timer_ovf, irq_ack} = 2'h3;
      tk(3);
      chk("tw1", 12'h001, timer_irq);
      chk("t0c", 12'h001, test_in_zero_oe);
      chk("t1l", 12'h001, t1_level);
      {timer_ovf, count_test_in} = 2'h0;
      tk(1);
      irq_ack = 1'b0;
      chk("ack", 12'h000, timer_irq);
      tk(2);
      chk("cnt", 12'h001, count_pulse);
      chk("p1l", 12'h0A5, p1_level);
      chk("p1e", 12'h05A, p1_oe);
      op_code = HALT_OPCODE;
      op_valid = 1'b1;
      tk(1);
      op_valid = 1'b0;
      tk(3);
      chk("hlt", 12'h001, halt_mode);
      int_n = 1'b0;
      tk(6);
      chk("wak", 12'h000, halt_mode);
      chk("lvl", 12'h001, int_level);
      chk("dis", 12'h000, ext_irq);
      ei_op = 1'b1;
      tk(1);
      ei_op = 1'b0;
      tk(3);
      chk("irq", 12'h001, ext_irq);
      // Halt with interrupts enabled: one more op before service
      int_n = 1'b1;
      tk(3);
      op_valid = 1'b1;
      tk(1);
      op_valid = 1'b0;
      tk(2);
      chk("hl2", 12'h001, halt_mode);
      int_n = 1'b0;
      tk(6);
      chk("hld", 12'h000, {halt_mode, ext_irq});
      op_code = 8'h00;
      op_valid = 1'b1;
      tk(1);
      op_valid = 1'b0;
      tk(2);
      chk("nxt", 12'h001, ext_irq);
      {int_n, reset_pin_n, standby_n} = 3'h4;
      tk(6);
      chk("stp", 12'h001, stop_mode);
      chk("crs", 12'h001, core_reset);
      // Supply comes back before reset lets go
      {int_n, reset_pin_n, standby_n} = 3'h1;
      tk(4);
      reset_pin_n = 1'b1;
      tk(8);
      chk("rel", 12'h000, stop_mode);
      chk("ien", 12'h000, ext_irq);
      end_sim();
   end
endmodule

// file: mxb_pkg.sv
// Shared constants and types for the external bus and pin control block
package mxb_pkg;

   // Clock and machine-cycle timing
   localparam int CLK_MHZ     = 50;
   localparam int SLOT_NS     = 500;                          // One state slot
   localparam int SLOT_CYC    = (SLOT_NS * CLK_MHZ + 999) / 1000;
   localparam int SLOT_CNT_W  = 8;

   // Memory sizes and program address width
   localparam int PC_W        = 12;
   localparam int ROM_BYTES   = 1024;
   localparam int ROM_AW      = 10;
   localparam int RAM_BYTES   = 64;
   localparam int RAM_AW      = 6;

   // Opcodes decoded here
   localparam logic [7:0] HALT_OPCODE = 8'h01;

   // Reset values
   localparam logic [7:0]  BUS_LATCH_RST = 8'h00;
   localparam logic [7:0]  PORT_RST      = 8'hFF;               // Quasi-bidir ports idle high
   localparam logic [30:0] SYNC_RST      = 31'h3800_0000;       // Standby, step and interrupt pins idle high; reset pin idles low

   // Bit positions inside the input synchroniser vector
   localparam int SY_RESET = 30;
   localparam int SY_STBY  = 29;
   localparam int SY_STEP  = 28;
   localparam int SY_INT   = 27;
   localparam int SY_EXT   = 26;
   localparam int SY_T0    = 25;
   localparam int SY_T1    = 24;
   localparam int SY_BUS   = 16;
   localparam int SY_P1    = 8;
   localparam int SY_P2    = 0;

   // Kinds of machine cycle the core may request
   typedef enum logic [3:0] {
      K_IDLE, K_FETCH, K_XRD, K_XWR, K_BUS_IN, K_BUS_OUT,
      K_EXP_RD, K_EXP_WR, K_RAM_RD, K_RAM_WR
   } mxb_kind_type;

   // State slots of one machine cycle
   typedef enum logic [2:0] {
      SL_ADDR, SL_LATCH, SL_STRB1, SL_STRB2, SL_END
   } mxb_slot_type;

endpackage
